// ===== design/lock_monitor_defines.vh
// register offsets, field layouts, reset values and widths of the lock monitor
`ifndef LOCK_MONITOR_DEFINES_VH
`define LOCK_MONITOR_DEFINES_VH
`define REG_PHASE_OFFSET    4'h0
`define REG_PHASE_THRESH    4'h1
`define REG_FREQ_THRESH     4'h2
`define REG_LOCK_CTRL       4'h3
`define REG_REF_CTRL        4'h4
`define REG_REF_A_WORD      4'h5
`define REG_REF_B_WORD      4'h6
`define REG_STATUS          4'h7
`define REG_IRQ_STATUS      4'h8
`define REG_PIN_ASSIGN      4'h9
`define OFFSET_W            14
`define SAMPLE_W            32
`define EXP_X_W             5
`define EXP_Y_W             3
`define WD_W                16
`define LOCK_PX_LSB         0
`define LOCK_PY_LSB         5
`define LOCK_FX_LSB         8
`define LOCK_FY_LSB         13
`define LOCK_PDIV_LSB       16
`define PDIV_W              4
`define RST_WD_WORD         16'hffff
`define RST_THRESH          32'h00000000
`define RST_LOCK_CTRL       32'h00000000
`endif

// ===== design/lock_qualifier.v
// lock qualifying / unlock interval detector driven by p-divider enable
`timescale 1ns/1ps
module lock_qualifier #(
  parameter CNT_W = 22
) (
  clk,
  sys_rst,
  pdiv_en,
  cmp_true,
  exp_lock,
  exp_unlock,
  locked
);
  input  wire             clk;
  input  wire             sys_rst;
  input  wire             pdiv_en;
  input  wire             cmp_true;
  input  wire [4:0]       exp_lock;
  input  wire [2:0]       exp_unlock;
  output wire             locked;

  reg              locked_ff;
  reg  [CNT_W-1:0] cnt_ff;
  reg              nxt_locked;
  reg  [CNT_W-1:0] nxt_cnt;
  wire [CNT_W-1:0] lock_lim;
  wire [CNT_W-1:0] unlock_lim;

  assign lock_lim   = {{(CNT_W-1){1'b0}}, 1'b1} << exp_lock;
  assign unlock_lim = {{(CNT_W-1){1'b0}}, 1'b1} << ({1'b0, exp_unlock} + 4'h1);
  assign locked     = locked_ff;

  always @* begin
    nxt_locked = locked_ff;
    nxt_cnt    = cnt_ff;
    if (pdiv_en) begin
      if (!locked_ff) begin
        if (cmp_true) begin
          nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
          if (nxt_cnt >= lock_lim) begin
            nxt_locked = 1'b1;
            nxt_cnt    = {CNT_W{1'b0}};
          end
        end else begin
          nxt_cnt = {CNT_W{1'b0}};
        end
      end else begin
        // lock held until an unlock event
        if (!cmp_true) begin
          nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
          if (nxt_cnt >= unlock_lim) begin
            nxt_locked = 1'b0;
            nxt_cnt    = {CNT_W{1'b0}};
          end
        end else begin
          nxt_cnt = {CNT_W{1'b0}};
        end
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      locked_ff <= 1'b0;
      cnt_ff    <= {CNT_W{1'b0}};
    end else begin
      locked_ff <= nxt_locked;
      cnt_ff    <= nxt_cnt;
    end
  end
endmodule // lock_qualifier

// ===== design/lock_ref_monitor.v
// dpll phase offset, phase/frequency lock detect and loss-of-reference monitor
// Overview of operation
// - add signed offset to every phase sample
// - phase offset held as 14-bit two's complement
// - compare sample magnitude against phase threshold
// - phase lock threshold is 32-bit unsigned
// - lock after 2^X true p-divider periods
// - lock held until unlock or reset
// - X is 5 bits, software keeps 0..20
// - unlock after 2^(Y+1) false periods, restart
// - unlock exponent Y is 3 bits
// - frequency lock from successive sample difference
// - frequency lock uses own exponent fields
// - two loss monitors, each individually enabled
// - loss sets status and interrupt status flag
// - loss flags routable to four status pins
// - watchdog restarts on rising edge, flags full
// - terminal count from own 16-bit word
// - watchdogs count at half system clock
// - p-divider ratio is power of two
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "lock_monitor_defines.vh"
module lock_ref_monitor #(
  parameter SAMPLE_W = `SAMPLE_W
) (
  clk,
  sys_rst,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  pd_sample,
  pd_sample_valid,
  corr_sample,
  corr_sample_valid,
  ref_input_a,
  ref_input_b,
  phase_locked,
  freq_locked,
  ref_loss_flag,
  multipurpose_status_pins
);
  input  wire                clk;
  input  wire                sys_rst;
  input  wire [5:0]          avs_address;
  input  wire                avs_read;
  input  wire                avs_write;
  input  wire [31:0]         avs_writedata;
  output reg  [31:0]         avs_readdata;
  output wire                avs_waitrequest;
  input  wire [SAMPLE_W-1:0] pd_sample;
  input  wire                pd_sample_valid;
  output reg  [SAMPLE_W-1:0] corr_sample;
  output reg                 corr_sample_valid;
  input  wire                ref_input_a;
  input  wire                ref_input_b;
  output wire                phase_locked;
  output wire                freq_locked;
  output wire [1:0]          ref_loss_flag;
  output reg  [3:0]          multipurpose_status_pins;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  reg  [`OFFSET_W-1:0] phase_offset_ff;
  reg  [31:0]          phase_lock_threshold_ff;
  reg  [31:0]          freq_lock_threshold_ff;
  reg  [31:0]          lock_ctrl_ff;
  reg  [1:0]           ref_en_ff;
  reg  [`WD_W-1:0]     wd_word_ff [0:1];
  reg  [1:0]           irq_status_ff;
  reg  [7:0]           pin_assign_ff;
  reg                  ack_ff;
  wire [3:0]           reg_idx;
  wire                 addr_ok;
  wire [1:0]           loss_evt;
  wire                 wr_go;
  wire                 wr_hit;
  wire [1:0]           irq_clr;
  wire [31:0]          status_word;
  reg  [31:0]          nxt_readdata;

  assign reg_idx         = avs_address[5:2];
  assign addr_ok         = (avs_address[1:0] == 2'h0) && (reg_idx <= `REG_PIN_ASSIGN);
  // one wait cycle, then the access completes
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr_go           = avs_write & ack_ff;
  assign wr_hit          = wr_go & addr_ok;
  // write one to clear, taken only from an accepted write to the event register
  assign irq_clr         = (wr_hit && (reg_idx == `REG_IRQ_STATUS)) ?
                           avs_writedata[1:0] : 2'h0;
  assign status_word     = {28'h0000000, ref_loss_flag, freq_locked, phase_locked};

  always @(posedge clk) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      phase_offset_ff         <= {`OFFSET_W{1'b0}};
      phase_lock_threshold_ff <= `RST_THRESH;
      freq_lock_threshold_ff  <= `RST_THRESH;
      lock_ctrl_ff            <= `RST_LOCK_CTRL;
      ref_en_ff               <= 2'h0;
      wd_word_ff[0]           <= `RST_WD_WORD;
      wd_word_ff[1]           <= `RST_WD_WORD;
      pin_assign_ff           <= 8'h00;
    end else if (wr_hit) begin
      case (reg_idx)
        `REG_PHASE_OFFSET: phase_offset_ff <= avs_writedata[`OFFSET_W-1:0];
        `REG_PHASE_THRESH: phase_lock_threshold_ff <= avs_writedata;
        `REG_FREQ_THRESH:  freq_lock_threshold_ff <= avs_writedata;
        `REG_LOCK_CTRL:    lock_ctrl_ff <= {12'h000, avs_writedata[19:0]};
        `REG_REF_CTRL:     ref_en_ff <= avs_writedata[1:0];
        `REG_REF_A_WORD:   wd_word_ff[0] <= avs_writedata[`WD_W-1:0];
        `REG_REF_B_WORD:   wd_word_ff[1] <= avs_writedata[`WD_W-1:0];
        `REG_PIN_ASSIGN:   pin_assign_ff <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // irq status: set wins over write-one-to-clear
  always @(posedge clk) begin
    if (sys_rst) begin
      irq_status_ff <= 2'h0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~irq_clr) | loss_evt;
    end
  end

  always @* begin
    nxt_readdata = 32'h00000000;
    if (addr_ok) begin
      case (reg_idx)
        `REG_PHASE_OFFSET: nxt_readdata = {{(32-`OFFSET_W){1'b0}}, phase_offset_ff};
        `REG_PHASE_THRESH: nxt_readdata = phase_lock_threshold_ff;
        `REG_FREQ_THRESH:  nxt_readdata = freq_lock_threshold_ff;
        `REG_LOCK_CTRL:    nxt_readdata = lock_ctrl_ff;
        `REG_REF_CTRL:     nxt_readdata = {30'h00000000, ref_en_ff};
        `REG_REF_A_WORD:   nxt_readdata = {16'h0000, wd_word_ff[0]};
        `REG_REF_B_WORD:   nxt_readdata = {16'h0000, wd_word_ff[1]};
        `REG_STATUS:       nxt_readdata = status_word;
        `REG_IRQ_STATUS:   nxt_readdata = {30'h00000000, irq_status_ff};
        `REG_PIN_ASSIGN:   nxt_readdata = {24'h000000, pin_assign_ff};
        default:           nxt_readdata = 32'h00000000;
      endcase
    end
  end

  // read data are captured in the wait cycle and stand at the completing edge
  always @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_ff) begin
      avs_readdata <= nxt_readdata;
    end
  end

  // ----------------------------------------------------------------
  // phase offset adder and sample magnitudes
  // ----------------------------------------------------------------
  reg  [SAMPLE_W-1:0] prev_sample_ff;
  reg                 have_prev_ff;
  reg                 ph_true_ff;
  reg                 fr_true_ff;
  wire [SAMPLE_W-1:0] offset_ext;
  wire [SAMPLE_W-1:0] sum;
  wire [SAMPLE_W-1:0] diff;
  wire [SAMPLE_W-1:0] sum_mag;
  wire [SAMPLE_W-1:0] diff_mag;
  wire                ph_cmp;
  wire                fr_cmp;

  assign offset_ext = {{(SAMPLE_W-`OFFSET_W){phase_offset_ff[`OFFSET_W-1]}},
                       phase_offset_ff};
  assign sum        = pd_sample + offset_ext;
  assign diff       = sum - prev_sample_ff;
  assign sum_mag    = sum[SAMPLE_W-1] ? (~sum + {{(SAMPLE_W-1){1'b0}}, 1'b1}) : sum;
  assign diff_mag   = diff[SAMPLE_W-1] ? (~diff + {{(SAMPLE_W-1){1'b0}}, 1'b1}) : diff;
  assign ph_cmp     = (sum_mag <= phase_lock_threshold_ff);
  // the first sample after reset has no predecessor and never counts as true
  assign fr_cmp     = have_prev_ff && (diff_mag <= freq_lock_threshold_ff);

  always @(posedge clk) begin
    if (sys_rst) begin
      corr_sample       <= {SAMPLE_W{1'b0}};
      corr_sample_valid <= 1'b0;
      prev_sample_ff    <= {SAMPLE_W{1'b0}};
      have_prev_ff      <= 1'b0;
      ph_true_ff        <= 1'b0;
      fr_true_ff        <= 1'b0;
    end else begin
      corr_sample_valid <= pd_sample_valid;
      if (pd_sample_valid) begin
        corr_sample    <= sum;
        prev_sample_ff <= sum;
        have_prev_ff   <= 1'b1;
        ph_true_ff     <= ph_cmp;
        fr_true_ff     <= fr_cmp;
      end
    end
  end

  // ----------------------------------------------------------------
  // p-divider enable, ratio 2^exponent
  // ----------------------------------------------------------------
  reg  [15:0]        pdiv_cnt_ff;
  wire [`PDIV_W-1:0] loop_divider_exponent;
  wire [15:0]        pdiv_last;
  wire               pdiv_en;
  wire [15:0]        pdiv_inc;

  assign loop_divider_exponent = lock_ctrl_ff[`LOCK_PDIV_LSB +: `PDIV_W];
  assign pdiv_inc  = pdiv_cnt_ff + 16'h0001;
  assign pdiv_last = (16'h0001 << loop_divider_exponent) - 16'h0001;
  assign pdiv_en   = (pdiv_cnt_ff >= pdiv_last);

  always @(posedge clk) begin
    if (sys_rst) begin
      pdiv_cnt_ff <= 16'h0000;
    end else begin
      pdiv_cnt_ff <= pdiv_en ? 16'h0000 : pdiv_inc;
    end
  end

  // ----------------------------------------------------------------
  // lock qualifiers
  // ----------------------------------------------------------------
  wire [`EXP_X_W-1:0] ph_exp_lock;
  wire [`EXP_Y_W-1:0] ph_exp_unlock;
  wire [`EXP_X_W-1:0] fr_exp_lock;
  wire [`EXP_Y_W-1:0] fr_exp_unlock;

  assign ph_exp_lock   = lock_ctrl_ff[`LOCK_PX_LSB +: `EXP_X_W];
  assign ph_exp_unlock = lock_ctrl_ff[`LOCK_PY_LSB +: `EXP_Y_W];
  assign fr_exp_lock   = lock_ctrl_ff[`LOCK_FX_LSB +: `EXP_X_W];
  assign fr_exp_unlock = lock_ctrl_ff[`LOCK_FY_LSB +: `EXP_Y_W];

  lock_qualifier #(.CNT_W(22)) u_phase_lock (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .pdiv_en    (pdiv_en),
    .cmp_true   (ph_true_ff),
    .exp_lock   (ph_exp_lock),
    .exp_unlock (ph_exp_unlock),
    .locked     (phase_locked)
  );

  lock_qualifier #(.CNT_W(22)) u_freq_lock (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .pdiv_en    (pdiv_en),
    .cmp_true   (fr_true_ff),
    .exp_lock   (fr_exp_lock),
    .exp_unlock (fr_exp_unlock),
    .locked     (freq_locked)
  );

  // ----------------------------------------------------------------
  // loss-of-reference watchdogs
  // ----------------------------------------------------------------
  // one watchdog tick every second system clock
  reg         half_en_ff;
  wire [1:0]  ref_in;

  assign ref_in = {ref_input_b, ref_input_a};

  always @(posedge clk) begin
    if (sys_rst) begin
      half_en_ff <= 1'b0;
    end else begin
      half_en_ff <= ~half_en_ff;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_wd
      reg              ref_d_ff;
      reg              edge_seen_ff;
      reg              loss_ff;
      reg [`WD_W-1:0]  wd_cnt_ff;
      wire             rise;
      wire             full;
      wire             last_cnt;
      wire [`WD_W-1:0] cnt_inc;
      assign rise     = ref_in[g] & ~ref_d_ff;
      assign full     = (wd_cnt_ff >= wd_word_ff[g]);
      assign cnt_inc  = wd_cnt_ff + {{(`WD_W-1){1'b0}}, 1'b1};
      assign last_cnt = (cnt_inc >= wd_word_ff[g]);
      assign ref_loss_flag[g] = loss_ff;
      // event pulse marks exactly the tick in which loss_ff is set below
      assign loss_evt[g]      = ref_en_ff[g] & half_en_ff & ~edge_seen_ff & ~rise &
                                ~full & last_cnt & ~loss_ff;
      always @(posedge clk) begin
        if (sys_rst || !ref_en_ff[g]) begin
          ref_d_ff     <= 1'b0;
          edge_seen_ff <= 1'b0;
          loss_ff      <= 1'b0;
          wd_cnt_ff    <= {`WD_W{1'b0}};
        end else begin
          ref_d_ff <= ref_in[g];
          if (rise) begin
            edge_seen_ff <= 1'b1;
          end
          if (half_en_ff) begin
            if (rise || edge_seen_ff) begin
              wd_cnt_ff    <= {`WD_W{1'b0}};
              edge_seen_ff <= 1'b0;
              loss_ff      <= 1'b0;
            end else if (!full) begin
              wd_cnt_ff <= cnt_inc;
              if (last_cnt) begin
                loss_ff <= 1'b1;
              end
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // status pin routing
  // ----------------------------------------------------------------
  integer i;
  always @(posedge clk) begin
    if (sys_rst) begin
      multipurpose_status_pins <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        multipurpose_status_pins[i] <= (pin_assign_ff[i] & ref_loss_flag[0]) |
                                       (pin_assign_ff[i+4] & ref_loss_flag[1]);
      end
    end
  end
endmodule // lock_ref_monitor

// ===== verification/lock_ref_monitor_checker.sv
// port-level assertions for the lock and reference-loss monitor
`timescale 1ns/1ps
module lock_ref_monitor_checker #(
  parameter SAMPLE_W = 32
) (
  input logic                clk,
  input logic                sys_rst,
  input logic [5:0]          avs_address,
  input logic                avs_read,
  input logic                avs_write,
  input logic [31:0]         avs_writedata,
  input logic [31:0]         avs_readdata,
  input logic                avs_waitrequest,
  input logic [SAMPLE_W-1:0] pd_sample,
  input logic                pd_sample_valid,
  input logic [SAMPLE_W-1:0] corr_sample,
  input logic                corr_sample_valid,
  input logic                ref_input_a,
  input logic                ref_input_b,
  input logic                phase_locked,
  input logic                freq_locked,
  input logic [1:0]          ref_loss_flag,
  input logic [3:0]          multipurpose_status_pins
);
  // ---------------------------------------------------------------
  // cycles since the last sampled rising edge of reference b
  // ---------------------------------------------------------------
  logic [7:0] quiet_b_ff;
  logic       prev_b_ff;
  logic [7:0] nxt_quiet_b;
  always_comb nxt_quiet_b = (ref_input_b && !prev_b_ff) ? 8'h00 :
                            quiet_b_ff + {7'h00, quiet_b_ff != 8'hff};
  always_ff @(posedge clk) begin
    prev_b_ff  <= sys_rst ? 1'b0 : ref_input_b;
    quiet_b_ff <= sys_rst ? 8'h00 : nxt_quiet_b;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wait_once;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  bus_wait_a: assert property ($rose(avs_read || avs_write) |-> s_wait_once)
    else $error("waitrequest not held for exactly one cycle");
  bus_idle_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  corr_pulse_a: assert property (pd_sample_valid |=> corr_sample_valid)
    else $error("corrected strobe missing");
  corr_only_a: assert property (!pd_sample_valid |=> !corr_sample_valid)
    else $error("corrected strobe without sample");
  corr_hold_a: assert property (!corr_sample_valid |-> $stable(corr_sample))
    else $error("corrected sample changed without strobe");
  plock_hold_a: assert property ($rose(phase_locked) |-> phase_locked [*2])
    else $error("phase lock dropped too soon");
  flock_hold_a: assert property ($rose(freq_locked) |-> freq_locked [*2])
    else $error("frequency lock dropped too soon");
  loss_clear_a: assert property ($rose(ref_input_b) |-> ##[1:4] !ref_loss_flag[1])
    else $error("reference edge did not clear loss");
  loss_quiet_a: assert property ($rose(ref_loss_flag[1]) |-> quiet_b_ff >= 8'd5)
    else $error("loss flagged too early");
  reset_clear_a: assert property (disable iff (1'b0) sys_rst |=>
    !phase_locked && !freq_locked && ref_loss_flag == 2'b00 && multipurpose_status_pins == 4'h0)
    else $error("outputs not cleared by reset");
endmodule // lock_ref_monitor_checker
bind lock_ref_monitor lock_ref_monitor_checker #(.SAMPLE_W(SAMPLE_W)) checker_i (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pd_sample(pd_sample), .pd_sample_valid(pd_sample_valid),
  .corr_sample(corr_sample), .corr_sample_valid(corr_sample_valid), .ref_input_a(ref_input_a),
  .ref_input_b(ref_input_b), .phase_locked(phase_locked), .freq_locked(freq_locked),
  .ref_loss_flag(ref_loss_flag), .multipurpose_status_pins(multipurpose_status_pins));

// ===== verification/ref_clock_pair.sv
// two reference clock sources that can be stopped to mimic a lost input
`timescale 1ns/1ps
module ref_clock_pair #(
  parameter HALF = 4
) (
  input  logic clk,
  input  logic run_a,
  input  logic run_b,
  output logic ref_a,
  output logic ref_b
);
  logic [7:0] div_ff = 8'h00;
  initial ref_a = 1'b0;
  initial ref_b = 1'b0;
  // a stopped source parks low, like a missing input
  always @(posedge clk) begin
    div_ff <= (div_ff == HALF - 1) ? 8'h00 : div_ff + 8'h01;
    if (div_ff == HALF - 1) begin
      ref_a <= run_a & ~ref_a;
      ref_b <= run_b & ~ref_b;
    end
  end
endmodule // ref_clock_pair

// ===== verification/dpll_lock_and_ref_loss_monitor_tb_top.sv
// self-checking bench for the lock and reference-loss monitor
`timescale 1ns/1ps
`include "lock_monitor_defines.vh"
module dpll_lock_and_ref_loss_monitor_tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] pd_sample = 32'h0;
  logic        pd_sample_valid = 1'b0;
  logic [31:0] corr_sample;
  logic        corr_sample_valid;
  logic        run_a = 1'b1;
  logic        run_b = 1'b1;
  logic        ref_a;
  logic        ref_b;
  logic        phase_locked;
  logic        freq_locked;
  logic [1:0]  ref_loss_flag;
  logic [3:0]  pins;
  logic [31:0] rd;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          offs [2] = '{-2048, 2047};
  lock_ref_monitor DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pd_sample(pd_sample),
    .pd_sample_valid(pd_sample_valid), .corr_sample(corr_sample),
    .corr_sample_valid(corr_sample_valid), .ref_input_a(ref_a), .ref_input_b(ref_b),
    .phase_locked(phase_locked), .freq_locked(freq_locked), .ref_loss_flag(ref_loss_flag),
    .multipurpose_status_pins(pins));
  ref_clock_pair src (.clk(clk), .run_a(run_a), .run_b(run_b), .ref_a(ref_a), .ref_b(ref_b));
  initial begin
    forever #10 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n == 100}, 32'h0, "bus answer timeout");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] idx, input logic [31:0] mask, input logic [31:0] exp,
                        input string msg);
    bus(1'b0, idx, 32'h0);
    chk(rd & mask, exp, msg);
  endtask
  task automatic stream(input logic [31:0] s, input int n);
    pd_sample <= s;
    pd_sample_valid <= 1'b1;
    repeat (n) @(posedge clk);
  endtask
  task automatic lk(input logic [31:0] exp, input string msg);
    chk({30'h0, freq_locked, phase_locked}, exp, msg);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test;
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++)
      if (i != 7 && i != 8)
        rd_chk(4'(i), 32'hffffffff, (i == 5 || i == 6) ? 32'hffff : 32'h0, "reset");
    bus(1'b1, 4'ha, 32'h55);
    rd_chk(4'ha, 32'hffffffff, 32'h0, "unmapped read");
    bus(1'b1, `REG_PHASE_OFFSET, 32'hffffffff);
    rd_chk(`REG_PHASE_OFFSET, 32'hffffffff, 32'h3fff, "offset width");
    bus(1'b1, `REG_PHASE_THRESH, 32'hfffffffe);
    rd_chk(`REG_PHASE_THRESH, 32'hffffffff, 32'hfffffffe, "threshold");
    bus(1'b1, `REG_LOCK_CTRL, 32'hfffff4f4);
    rd_chk(`REG_LOCK_CTRL, 32'hffffffff, 32'h000ff4f4, "lock fields");
    bus(1'b1, `REG_REF_A_WORD, 32'h1234);
    rd_chk(`REG_REF_A_WORD, 32'hffff, 32'h1234, "watchdog word");
    $display("test registers done");
    foreach (offs[k]) begin
      bus(1'b1, `REG_PHASE_OFFSET, 32'(offs[k]) & 32'h3fff);
      stream(32'd100, 1);
      pd_sample_valid <= 1'b0;
      @(posedge clk);
      chk(corr_sample, 32'(100 + offs[k]), "corrected sample");
      chk({31'h0, corr_sample_valid}, 32'h1, "corrected strobe");
    end
    $display("test offset done");
    bus(1'b1, `REG_PHASE_OFFSET, 32'h0);
    bus(1'b1, `REG_PHASE_THRESH, 32'd10);
    bus(1'b1, `REG_FREQ_THRESH, 32'd5);
    bus(1'b1, `REG_LOCK_CTRL, 32'h0202);
    for (int i = 0; i < 10; i++) begin
      stream(32'd1000, 1);
      stream(-32'sd1000, 1);
    end
    lk(32'h0, "unlocked on large swings");
    stream(-32'sd10, 12);
    lk(32'h3, "locked at threshold");
    rd_chk(`REG_STATUS, 32'hf, 32'h3, "status lock bits");
    stream(32'd11, 3);
    lk(32'h3, "lock held over short error");
    stream(32'd11, 12);
    lk(32'h2, "phase unlock, frequency held");
    bus(1'b1, `REG_LOCK_CTRL, 32'h30202);
    stream(-32'sd10, 16);
    chk({31'h0, phase_locked}, 32'h0, "slow divider not yet locked");
    stream(-32'sd10, 50);
    chk({31'h0, phase_locked}, 32'h1, "slow divider locked");
    pd_sample_valid <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    lk(32'h0, "reset clears lock");
    sys_rst <= 1'b0;
    @(posedge clk);
    rd_chk(`REG_LOCK_CTRL, 32'hffffffff, 32'h0, "lock ctrl after reset");
    $display("test lock done");
    bus(1'b1, `REG_REF_A_WORD, 32'd5);
    bus(1'b1, `REG_REF_B_WORD, 32'd10);
    bus(1'b1, `REG_PIN_ASSIGN, 32'h21);
    bus(1'b1, `REG_REF_CTRL, 32'h1);
    run_b <= 1'b0;
    repeat (60) @(posedge clk);
    chk({30'h0, ref_loss_flag}, 32'h0, "disabled monitor quiet");
    bus(1'b1, `REG_REF_CTRL, 32'h3);
    repeat (60) @(posedge clk);
    chk({30'h0, ref_loss_flag}, 32'h2, "loss on b only");
    chk({28'h0, pins}, 32'h2, "loss routed to pin");
    rd_chk(`REG_STATUS, 32'hc, 32'h8, "status loss");
    rd_chk(`REG_IRQ_STATUS, 32'h3, 32'h2, "event loss");
    run_b <= 1'b1;
    repeat (30) @(posedge clk);
    chk({30'h0, ref_loss_flag}, 32'h0, "loss cleared by edge");
    bus(1'b1, `REG_IRQ_STATUS, 32'h2);
    rd_chk(`REG_IRQ_STATUS, 32'h3, 32'h0, "event cleared");
    $display("test reference loss done");
    stop_test;
  end
endmodule // dpll_lock_and_ref_loss_monitor_tb_top
